/* rtl/ttc_pkg.sv */
// Shared constants and types of the triple timer/counter block.
// Assumes a single system clock with four clock phases per machine cycle.
package ttc_pkg;

   typedef logic [7:0]  ttc_byte_t;
   typedef logic [15:0] ttc_word_t;

   // Machine-cycle timing in system clocks.
   localparam int unsigned CLK_HZ         = 10_000_000;
   localparam int unsigned CLKS_PER_MC    = 4;
   localparam int unsigned MC_PER_SLOW    = 3;
   localparam logic [1:0]  PHASE_C3       = 2'h2;
   localparam logic [1:0]  PHASE_C4       = 2'h3;
   localparam logic [1:0]  PHASE_LAST     = 2'(CLKS_PER_MC - 1);
   localparam logic [1:0]  SLOW_LAST      = 2'(MC_PER_SLOW - 1);

   // Field positions inside the timer mode register.
   localparam int unsigned MODE0_LSB      = 0;
   localparam int unsigned CT0_BIT        = 2;
   localparam int unsigned GATE0_BIT      = 3;
   localparam int unsigned MODE1_LSB      = 4;
   localparam int unsigned CT1_BIT        = 6;
   localparam int unsigned GATE1_BIT      = 7;

   // Operating modes of timers zero and one.
   localparam logic [1:0]  MODE_13BIT     = 2'h0;
   localparam logic [1:0]  MODE_16BIT     = 2'h1;
   localparam logic [1:0]  MODE_RELOAD8   = 2'h2;
   localparam logic [1:0]  MODE_SPLIT     = 2'h3;

   // Count write selector codes.
   localparam logic [2:0]  SEL_LO0        = 3'h0;
   localparam logic [2:0]  SEL_HI0        = 3'h1;
   localparam logic [2:0]  SEL_LO1        = 3'h2;
   localparam logic [2:0]  SEL_HI1        = 3'h3;
   localparam logic [2:0]  SEL_LO2        = 3'h4;
   localparam logic [2:0]  SEL_HI2        = 3'h5;
   localparam logic [2:0]  SEL_CAPLO      = 3'h6;
   localparam logic [2:0]  SEL_CAPHI      = 3'h7;

   // Reset and limit values.
   localparam ttc_byte_t   BYTE_RST       = 8'h00;
   localparam ttc_word_t   WORD_RST       = 16'h0000;
   localparam ttc_word_t   WORD_MAX       = 16'hFFFF;
   localparam ttc_byte_t   BYTE_MAX       = 8'hFF;

   // Timer 2 operating modes, one-hot.
   typedef enum logic [3:0] {
      TMR2_CAPTURE = 4'h1,
      TMR2_RELOAD  = 4'h2,
      TMR2_UPDOWN  = 4'h4,
      TMR2_BAUD    = 4'h8
   } ttc_tmr2_mode_t;

endpackage : ttc_pkg

/* rtl/ttc_phase_if.sv */
// Carrier between the phase generator and the counting logic.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface ttc_phase_if;
   logic       c3;
   logic       slow;
   logic [3:0] fall;
   logic       dir_up;

   modport src (output c3, output slow, output fall, output dir_up);
   modport dst (input c3, input slow, input fall, input dir_up);
endinterface : ttc_phase_if

/* rtl/ttc_phase.sv */
// Machine-cycle phase generator and C4 pin sampler with edge detection.
// Assumes pins are synchronous to clk.
`timescale 1ns/100ps
module ttc_phase
   import ttc_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Sampled pins: count zero, count one, count two, external
   input  wire logic [3:0] pins,
   // Timing towards the counters
   ttc_phase_if.src        ph
);
   logic [1:0] phase_q;
   logic [1:0] slow_q;
   logic [3:0] samp_q;
   logic [3:0] prev_q;
   logic       at_c4;
   logic       mc_end;

   assign at_c4  = (phase_q == PHASE_C4);
   assign mc_end = (phase_q == PHASE_LAST);

   // Phase and the divide-by-three machine-cycle counter for the slow rate.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_q <= 2'h0;
         slow_q  <= 2'h0;
      end else begin
         phase_q <= mc_end ? 2'h0 : phase_q + 2'h1;
         if (mc_end) begin
            slow_q <= (slow_q == SLOW_LAST) ? 2'h0 : slow_q + 2'h1;
         end
      end
   end

   // Pins are sampled once per machine cycle, at C4.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         samp_q <= 4'h0;
         prev_q <= 4'h0;
      end else if (at_c4) begin
         samp_q <= pins;  // R01
         prev_q <= samp_q;
      end
   end

   // The edge stays visible until the next C4, so the following C3 sees it.
   assign ph.c3     = (phase_q == PHASE_C3);
   assign ph.slow   = (slow_q == 2'h0);
   assign ph.fall   = prev_q & ~samp_q;  // R01 R02
   assign ph.dir_up = samp_q[3];

   a_fall_detect: assert property (@(posedge clk) disable iff (!rst_n) // R01
      at_c4 && samp_q[0] && !pins[0] |=> ph.fall[0] [*4])
      else $error("falling sample not held as an edge");

endmodule : ttc_phase

/* rtl/ttc_top.sv */
// Three timer/counters: two classic four-mode timers and a capture timer.
// Assumes control bits and pins are synchronous levels on clk.
//
// Operation
// R01: Sample count pins once per machine cycle; high then low is an edge.
// R02: Counts change at C3, so an edge counts in the next cycle.
// R03: Timer clock is one twelfth or one quarter rate per speed bit.
// R04: Mode register bit 2 and bit 6 pick timer or counter.
// R05: Mode 0 is thirteen bits: high byte plus five low bits.
// R06: Timers count only when run and gate released or pin high.
// R07: Mode 0 wrap from 1FFF sets the overflow flag.
// R08: Mode 1 is mode 0 with a full sixteen-bit count.
// R09: Mode 2 low byte wraps, sets flag, reloads from high byte.
// R10: Timer zero mode 3 splits; high byte uses timer one run and flag.
// R11: Timer one in mode 3 stops and holds its value.
// R12: During split, timer one counts machine cycles with no flag.
// R13: Timer 2 counts pin edges or divided clock; run bit gates it.
// R14: Capture mode counts up and flags the wrap from FFFF.
// R15: In capture mode an external edge copies the count and flags.
// R16: Capture-clear bit zeros the timer 2 count after each capture.
// R17: Up auto-reload mode reloads from capture registers on wrap.
// R18: In up reload mode an external edge reloads and flags.
// R19: Up/down mode direction follows external pin: high up, low down.
// R20: Up/down wrap reloads; down match loads FFFF; both set flag.
// R21: Up/down reloads toggle the event flag, which never interrupts.
// R22: Baud mode reloads on wrap without flag; external edge flags.
// R23: Timer 2 interrupt is overflow OR event flag; no hardware clear.
// R24: Timer zero and one flags clear on service routine entry.
// R25: Software count writes beat hardware updates in the same cycle.
`timescale 1ns/100ps
module ttc_top
   import ttc_pkg::*;
(
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst_n,
   // Timers zero and one control
   input  wire ttc_pkg::ttc_byte_t timer_mode_reg,
   input  wire logic               timer_zero_run_bit,
   input  wire logic               timer_one_run_bit,
   input  wire logic               timer_zero_speed_bit,
   input  wire logic               timer_one_speed_bit,
   // Timer 2 control
   input  wire logic               timer2_run_bit,
   input  wire logic               timer2_source_select,
   input  wire logic               timer2_speed_bit,
   input  wire logic               capture_reload_select,
   input  wire logic               external_event_enable,
   input  wire logic               capture_clear_bit,
   input  wire logic               down_count_enable,
   input  wire logic               rx_baud_clock_select,
   input  wire logic               tx_baud_clock_select,
   // Flag clearing
   input  wire logic               timer_zero_flag_clear,
   input  wire logic               timer_one_flag_clear,
   input  wire logic               timer_zero_isr_entry,
   input  wire logic               timer_one_isr_entry,
   input  wire logic               timer2_flag_clear,
   input  wire logic               external_event_clear,
   // Count and capture register writes
   input  wire logic               count_write_en,
   input  wire logic [2:0]         count_write_sel,
   input  wire ttc_pkg::ttc_byte_t count_write_data,
   // Pins
   input  wire logic               count_pin_zero,
   input  wire logic               count_pin_one,
   input  wire logic               count_pin_two,
   input  wire logic               timer2_external_pin,
   input  wire logic               external_interrupt_pin_zero_n,
   input  wire logic               external_interrupt_pin_one_n,
   // Count values
   output logic [7:0]              timer_zero_low_byte,
   output logic [7:0]              timer_zero_high_byte,
   output logic [7:0]              timer_one_low_byte,
   output logic [7:0]              timer_one_high_byte,
   output logic [7:0]              timer2_low_byte,
   output logic [7:0]              timer2_high_byte,
   output logic [7:0]              capture_low_byte,
   output logic [7:0]              capture_high_byte,
   // Flags and interrupt
   output logic                    timer_zero_overflow_flag,
   output logic                    timer_one_overflow_flag,
   output logic                    timer2_overflow_flag,
   output logic                    external_event_flag,
   output logic                    timer2_irq
);
   import ttc_pkg::*;

   // One hardware step of a classic timer: {overflow, high, low}.
   function automatic logic [16:0] ttc_step(input logic [1:0] m,
      input ttc_byte_t h, input ttc_byte_t l, input logic en);
      logic [16:0] r;
      logic [13:0] s13;
      logic [16:0] s16;
      logic [8:0]  s8;
      r   = {1'b0, h, l};
      s13 = {1'b0, h, l[4:0]} + 14'h0001;
      s16 = {1'b0, h, l} + 17'h00001;
      s8  = {1'b0, l} + 9'h001;
      if (en) begin
         case (m)
            MODE_13BIT:   r = {s13[13], s13[12:5], l[7:5], s13[4:0]};
            MODE_16BIT:   r = s16;
            MODE_RELOAD8: r = s8[8] ? {1'b1, h, h} : {1'b0, h, s8[7:0]};
            default:      r = {s8[8], h, s8[7:0]};
         endcase
      end
      return r;
   endfunction : ttc_step

   ttc_phase_if ph ();

   ttc_phase u_phase (
      .clk   (clk),
      .rst_n (rst_n),
      .pins  ({timer2_external_pin, count_pin_two, count_pin_one,
               count_pin_zero}),
      .ph    (ph.src)
   );

   ttc_byte_t      lo_q [2];
   ttc_byte_t      hi_q [2];
   ttc_word_t      cnt2_q, cnt2_d, cap2_q, cap2_d;
   logic           tf0_q, tf1_q, tf2_q, external_event_flag_q, irq_q;
   logic           tf2_set, exf_set, exf_tog;
   ttc_tmr2_mode_t mode2;

   // Mode fields and the timer-or-counter choice.
   logic [1:0] mode_a, mode_b;
   logic       ct_a, ct_b, split;
   assign mode_a = timer_mode_reg[MODE0_LSB +: 2];
   assign mode_b = timer_mode_reg[MODE1_LSB +: 2];
   assign ct_a   = timer_mode_reg[CT0_BIT];  // R04
   assign ct_b   = timer_mode_reg[CT1_BIT] & ~split;  // R04 R12
   assign split  = (mode_a == MODE_SPLIT);

   // Ticks land only at C3; a counter edge seen at C4 counts next cycle.
   logic fast_a, fast_b, tick_a, tick_b, run_a, run_b, en_a, en_b, en_hi0;
   assign fast_a = ph.c3 & (timer_zero_speed_bit | ph.slow);  // R03
   assign fast_b = ph.c3 & (timer_one_speed_bit | ph.slow);  // R03
   assign tick_a = ct_a ? (ph.c3 & ph.fall[0]) : fast_a;  // R02
   assign tick_b = ct_b ? (ph.c3 & ph.fall[1]) : fast_b;  // R02
   assign run_a  = timer_zero_run_bit &
      (~timer_mode_reg[GATE0_BIT] | external_interrupt_pin_zero_n);  // R06
   // While split, timer one has lost its run bit and just counts cycles.
   assign run_b  = split ? 1'b1 : timer_one_run_bit &
      (~timer_mode_reg[GATE1_BIT] | external_interrupt_pin_one_n);  // R06 R12
   assign en_a   = tick_a & run_a;
   assign en_b   = tick_b & run_b & (mode_b != MODE_SPLIT);  // R11
   assign en_hi0 = split & fast_a & timer_one_run_bit;  // R10

   logic [16:0] step_a, step_b;
   ttc_byte_t   hi0_hw;
   logic        ov_a, ov_b, ov_hi0;
   assign step_a = ttc_step(mode_a, hi_q[0], lo_q[0], en_a);  // R05 R08 R09
   assign step_b = ttc_step(mode_b, hi_q[1], lo_q[1], en_b);  // R05 R08 R09
   assign ov_a   = step_a[16];  // R07
   assign ov_b   = step_b[16] & ~split;  // R12
   assign ov_hi0 = en_hi0 & (hi_q[0] == BYTE_MAX);  // R10
   assign hi0_hw = split ? (en_hi0 ? hi_q[0] + 8'h01 : hi_q[0])
                         : step_a[15:8];  // R10

   // Write strobes, one per byte.
   logic [7:0] wr_hit;
   assign wr_hit = count_write_en ? (8'h01 << count_write_sel) : 8'h00;

   // Classic timer bytes; a software write wins over the hardware step.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lo_q[0] <= BYTE_RST;
         hi_q[0] <= BYTE_RST;
         lo_q[1] <= BYTE_RST;
         hi_q[1] <= BYTE_RST;
      end else begin
         lo_q[0] <= wr_hit[SEL_LO0] ? count_write_data : step_a[7:0];  // R25
         hi_q[0] <= wr_hit[SEL_HI0] ? count_write_data : hi0_hw;  // R25
         lo_q[1] <= wr_hit[SEL_LO1] ? count_write_data : step_b[7:0];  // R25
         hi_q[1] <= wr_hit[SEL_HI1] ? count_write_data : step_b[15:8];  // R25
      end
   end

   // Timer 2 mode decode; baud use takes precedence over the others.
   logic baud, tick2, ev2, wrap2;
   assign baud  = rx_baud_clock_select | tx_baud_clock_select;
   assign mode2 = baud ? TMR2_BAUD :
                  capture_reload_select ? TMR2_CAPTURE :
                  down_count_enable ? TMR2_UPDOWN : TMR2_RELOAD;
   assign tick2 = timer2_run_bit & (timer2_source_select ?
                  (ph.c3 & ph.fall[2]) :
                  (ph.c3 & (timer2_speed_bit | ph.slow)));  // R13
   assign ev2   = ph.c3 & external_event_enable & ph.fall[3];
   assign wrap2 = (cnt2_q == WORD_MAX);

   // Timer 2 next count, capture value and flag events.
   always_comb begin
      cnt2_d  = cnt2_q;
      cap2_d  = cap2_q;
      tf2_set = 1'b0;
      exf_set = 1'b0;
      exf_tog = 1'b0;
      case (mode2)
         TMR2_CAPTURE: begin
            if (tick2) begin
               cnt2_d  = cnt2_q + 16'h0001;  // R14
               tf2_set = wrap2;  // R14
            end
            if (ev2) begin
               cap2_d  = cnt2_q;  // R15
               exf_set = 1'b1;  // R15
               if (capture_clear_bit) begin
                  cnt2_d = WORD_RST;  // R16
               end
            end
         end
         TMR2_RELOAD: begin
            if (tick2) begin
               cnt2_d  = wrap2 ? cap2_q : cnt2_q + 16'h0001;  // R17
               tf2_set = wrap2;  // R17
            end
            if (ev2) begin
               cnt2_d  = cap2_q;  // R18
               exf_set = 1'b1;  // R18
            end
         end
         TMR2_UPDOWN: begin
            if (tick2 && ph.dir_up) begin  // R19
               cnt2_d  = wrap2 ? cap2_q : cnt2_q + 16'h0001;  // R20
               tf2_set = wrap2;  // R20
            end else if (tick2) begin
               cnt2_d  = (cnt2_q == cap2_q) ? WORD_MAX
                                            : cnt2_q - 16'h0001;  // R20
               tf2_set = (cnt2_q == cap2_q);  // R20
            end
            exf_tog = tf2_set;  // R21
         end
         TMR2_BAUD: begin
            if (tick2) begin
               cnt2_d = wrap2 ? cap2_q : cnt2_q + 16'h0001;  // R22
            end
            exf_set = ev2;  // R22
         end
         default: begin
            cnt2_d = cnt2_q;
         end
      endcase
      if (wr_hit[SEL_LO2]) cnt2_d[7:0]  = count_write_data;  // R25
      if (wr_hit[SEL_HI2]) cnt2_d[15:8] = count_write_data;  // R25
      if (wr_hit[SEL_CAPLO]) cap2_d[7:0]  = count_write_data;  // R25
      if (wr_hit[SEL_CAPHI]) cap2_d[15:8] = count_write_data;  // R25
   end

   // Flags: a set in the same cycle as a clear always wins.
   logic tf0_d, tf1_d, tf2_d, external_event_flag_d;
   assign tf0_d  = ov_a | (tf0_q &
      ~(timer_zero_flag_clear | timer_zero_isr_entry));  // R07 R24
   assign tf1_d  = ov_b | ov_hi0 | (tf1_q &
                   ~(timer_one_flag_clear | timer_one_isr_entry));  // R10 R24
   assign tf2_d  = tf2_set | (tf2_q & ~timer2_flag_clear);  // R23
   assign external_event_flag_d = exf_tog ? ~external_event_flag_q :
                   (exf_set | (external_event_flag_q & ~external_event_clear));  // R21

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt2_q <= WORD_RST;
         cap2_q <= WORD_RST;
         tf0_q  <= 1'b0;
         tf1_q  <= 1'b0;
         tf2_q  <= 1'b0;
         external_event_flag_q <= 1'b0;
         irq_q  <= 1'b0;
      end else begin
         cnt2_q <= cnt2_d;
         cap2_q <= cap2_d;
         tf0_q  <= tf0_d;
         tf1_q  <= tf1_d;
         tf2_q  <= tf2_d;
         external_event_flag_q <= external_event_flag_d;
         irq_q  <= tf2_d | (external_event_flag_d & (mode2 != TMR2_UPDOWN));  // R21 R23
      end
   end

   // Outputs all come from the registers above.
   assign timer_zero_low_byte      = lo_q[0];
   assign timer_zero_high_byte     = hi_q[0];
   assign timer_one_low_byte       = lo_q[1];
   assign timer_one_high_byte      = hi_q[1];
   assign timer2_low_byte          = cnt2_q[7:0];
   assign timer2_high_byte         = cnt2_q[15:8];
   assign capture_low_byte         = cap2_q[7:0];
   assign capture_high_byte        = cap2_q[15:8];
   assign timer_zero_overflow_flag = tf0_q;
   assign timer_one_overflow_flag  = tf1_q;
   assign timer2_overflow_flag     = tf2_q;
   assign external_event_flag      = external_event_flag_q;
   assign timer2_irq               = irq_q;

   // Checks on the counting behaviour.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_count_at_c3: assert property (!$stable(lo_q[0]) // R02
      && !$past(wr_hit[SEL_LO0]) |-> $past(ph.c3))
      else $error("low byte moved outside C3");
   a_ovf_sets_flag: assert property (ov_a |=> tf0_q) // R07
      else $error("overflow did not set the flag");
   a_reload_low: assert property (mode_a == MODE_RELOAD8 && en_a && // R09
      lo_q[0] == BYTE_MAX && wr_hit == 8'h00
      |=> lo_q[0] == $past(hi_q[0]) && hi_q[0] == $past(hi_q[0]))
      else $error("mode 2 reload wrong");
   a_frozen_one: assert property (mode_b == MODE_SPLIT // R11
      && wr_hit == 8'h00 |=> $stable(lo_q[1]) && $stable(hi_q[1]))
      else $error("timer one moved in mode 3");
   a_capture_copy: assert property (mode2 == TMR2_CAPTURE && ev2 && // R15
      wr_hit == 8'h00 |=> cap2_q == $past(cnt2_q) && external_event_flag_q)
      else $error("capture did not copy the count");
   a_capture_zero: assert property (mode2 == TMR2_CAPTURE && ev2 && // R16
      capture_clear_bit && wr_hit == 8'h00 |=> cnt2_q == WORD_RST)
      else $error("count not cleared after capture");
   a_down_match: assert property (mode2 == TMR2_UPDOWN && tick2 && // R20
      !ph.dir_up && cnt2_q == cap2_q && wr_hit == 8'h00
      |=> cnt2_q == WORD_MAX && tf2_q && external_event_flag_q != $past(external_event_flag_q))
      else $error("down match did not load all ones");
   a_baud_no_flag: assert property (mode2 == TMR2_BAUD && !tf2_q // R22
      |=> !tf2_q)
      else $error("baud mode set the overflow flag");
   a_irq_follows: assert property (tf2_q && !timer2_flag_clear // R23
      |=> timer2_irq && tf2_q)
      else $error("overflow flag did not raise the interrupt");
   a_write_wins: assert property (wr_hit[SEL_LO0] // R25
      |=> lo_q[0] == $past(count_write_data))
      else $error("write lost to hardware update");

   c_split_ovf: cover property (split && ov_hi0);
   c_capture: cover property (mode2 == TMR2_CAPTURE && ev2);
   c_down_reload: cover property (mode2 == TMR2_UPDOWN && tf2_set &&
      !ph.dir_up);
   c_mode0_wrap: cover property (mode_a == MODE_13BIT && ov_a);

endmodule : ttc_top

/* tb/ttc_pins.sv */
// Pin model: count pins, timer 2 external pin and gate pins.
// Assumes the bench clock; pins change on its falling edge only.
`timescale 1ns/100ps
module ttc_pins (
   // Clock
   input  wire logic  clk,
   // Pins and gate pins
   output logic [3:0] pin,
   output logic [1:0] gate_n
);
   // Idle pins rest high on their pull-ups.
   initial {pin, gate_n} = 6'h3F;
   // Each level is held two machine cycles, twice the minimum.
   task automatic pulses(input logic [3:0] m, input int n);
      repeat (n) begin
         @(negedge clk) pin = pin & ~m;
         repeat (8) @(negedge clk);
         pin = pin | m;
         repeat (8) @(negedge clk);
      end
   endtask : pulses
   // Direction and gating are plain held levels.
   task automatic level(input logic [3:0] m, input logic [1:0] g);
      @(negedge clk) pin = g[0] ? pin | m : pin & ~m;
      gate_n = {2{g[1]}};
   endtask : level
endmodule : ttc_pins

/* tb/testbench.sv */
// Self-checking bench of the triple timer/counter.
// Assumes the pin model; inputs change on the falling clock edge.
`timescale 1ns/100ps
module testbench;
   import ttc_pkg::*;
   logic       clk, rst_n, we, r0, r1, r2, s0, s1, s2, src, cp, eex;
   logic       cc, dc, f0, f1, f2, ef, irq;
   logic [1:0] bd, gn;
   logic [5:0] clr;
   logic [2:0] ws;
   logic [3:0] pin;
   ttc_byte_t  tmode, wd, t0l, t0h, t1l, t1h, t2l, t2h, c_lo, c_hi;
   int         fails, n_checks, it, t, m, hi, lo, k, sp, g, n, v, f;
   int         ehi, elo, i, s;
   ttc_pins ttc_pins_i (.clk(clk), .pin(pin), .gate_n(gn));
   ttc_top ttc_top_i (.clk(clk), .rst_n(rst_n), .timer_mode_reg(tmode),
      .timer_zero_run_bit(r0), .timer_one_run_bit(r1),
      .timer_zero_speed_bit(s0), .timer_one_speed_bit(s1),
      .timer2_run_bit(r2), .timer2_source_select(src),
      .timer2_speed_bit(s2), .capture_reload_select(cp),
      .external_event_enable(eex), .capture_clear_bit(cc),
      .down_count_enable(dc), .rx_baud_clock_select(bd[0]),
      .tx_baud_clock_select(bd[1]), .timer_zero_flag_clear(clr[0]),
      .timer_one_flag_clear(clr[1]), .timer_zero_isr_entry(clr[2]),
      .timer_one_isr_entry(clr[3]), .timer2_flag_clear(clr[4]),
      .external_event_clear(clr[5]), .count_write_en(we),
      .count_write_sel(ws), .count_write_data(wd),
      .count_pin_zero(pin[0]), .count_pin_one(pin[1]),
      .count_pin_two(pin[2]), .timer2_external_pin(pin[3]),
      .external_interrupt_pin_zero_n(gn[0]),
      .external_interrupt_pin_one_n(gn[1]),
      .timer_zero_low_byte(t0l), .timer_zero_high_byte(t0h),
      .timer_one_low_byte(t1l), .timer_one_high_byte(t1h),
      .timer2_low_byte(t2l), .timer2_high_byte(t2h),
      .capture_low_byte(c_lo), .capture_high_byte(c_hi),
      .timer_zero_overflow_flag(f0), .timer_one_overflow_flag(f1),
      .timer2_overflow_flag(f2), .external_event_flag(ef),
      .timer2_irq(irq));
   // Clock of 100 ns period.
   initial clk = 1'b0;
   always #50 clk = ~clk;
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [2:0] sel, input ttc_byte_t d);
      @(negedge clk) {we, ws, wd} = {1'b1, sel, d};
      @(negedge clk) we = 1'b0;
   endtask : wr
   task automatic t2w(input logic [15:0] w);
      wr(SEL_LO2, w[7:0]);
      wr(SEL_HI2, w[15:8]);
   endtask : t2w
   task automatic clrp(input logic [5:0] c);
      @(negedge clk) clr = c;
      @(negedge clk) clr = 6'h00;
   endtask : clrp
   // Run for a multiple of four clocks, so the tick count is exact.
   task automatic go(input logic [2:0] r, input int nc);
      @(negedge clk) {r2, r1, r0} = r;
      repeat (nc) @(negedge clk);
      {r2, r1, r0} = 3'h0;
   endtask : go
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : close_out
   // The run needs well under a tenth of this span.
   initial begin
      #2_000_000;
      fails++;
      close_out();
   end
   // Main sequence.
   initial begin
      {rst_n, we, ws, wd, tmode, clr, bd} = '0;
      {r0, r1, r2, s0, s1, s2, src, cp, eex, cc, dc} = '0;
      fails = 0;
      n_checks = 0;
      s = $urandom(39230);
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      chk({t0h, t0l, t1h, t1l} | {t2h, t2l, c_hi, c_lo}, 0);
      // Random starts near the top, random speed and gating.
      for (it = 0; it < 12; it++) begin
         t = it % 2;
         m = it / 4;
         hi = 255 - $urandom % 2;
         lo = 248 + $urandom % 8;
         k = 1 + $urandom % 8;
         sp = $urandom % 2;
         g = $urandom % 4;
         tmode = t ? {g[0], 3'(m), 4'h0} : {4'h0, g[0], 3'(m)};
         {s1, s0} = {2{sp[0]}};
         ttc_pins_i.level(4'h0, {g[1], 1'b1});
         wr(t ? SEL_HI1 : SEL_HI0, 8'(hi));
         wr(t ? SEL_LO1 : SEL_LO0, 8'(lo));
         clrp(6'h03);
         go(t ? 3'h2 : 3'h1, k * (sp ? 4 : 12));
         n = (g[0] && !g[1]) ? 0 : k;
         v = (m == 0) ? hi * 32 + lo % 32 + n : hi * 256 + lo + n;
         f = (m == 0) ? v > 8191 : v > 65535;
         ehi = (m == 0) ? v % 8192 / 32 : v / 256 % 256;
         elo = (m == 0) ? lo / 32 * 32 + v % 32 : v % 256;
         if (m == 2) begin
            {f, ehi, elo} = {0, hi, lo};
            for (i = 0; i < n; i++) begin
               f = f | (elo == 255);
               elo = (elo == 255) ? hi : elo + 1;
            end
         end
         chk({t ? {t1h, t1l} : {t0h, t0l}, t ? f1 : f0},
             {ehi[7:0], elo[7:0], f[0]});
      end
      // Split mode: high byte takes timer one's run and flag.
      // Fast rate, so twelve clocks give exactly three ticks.
      {tmode, s1, s0} = {8'h33, 2'h3};
      wr(SEL_LO0, 8'hFE);
      wr(SEL_HI0, 8'hFF);
      wr(SEL_LO1, 8'h10);
      clrp(6'h03);
      go(3'h3, 12);
      chk({t0h, t0l, t1l, f1, f0}, 26'h0080443);
      clrp(6'h0C);
      chk({f1, f0}, 2'h0);
      // Timer one in mode 1 during split counts with no run bit or flag.
      wr(SEL_HI1, 8'hFF);
      wr(SEL_LO1, 8'hFF);
      @(negedge clk) tmode = 8'h13;
      repeat (8) @(negedge clk);
      tmode = 8'h33;
      chk({t1h, t1l, f1}, 17'h00002);
      // Counter function on both count pins.
      tmode = 8'h55;
      for (i = 0; i < 4; i++) wr(SEL_LO0 + 3'(i), 8'h00);
      {r1, r0} = 2'h3;
      ttc_pins_i.pulses(4'h3, 3);
      repeat (8) @(negedge clk);
      {r1, r0} = 2'h0;
      chk({t1h, t1l, t0h, t0l}, 32'h00030003);
      // Timer 2 capture-mode wrap, then capture with clear.
      {s2, cp} = 2'h3;
      t2w(16'hFFFF);
      go(3'h4, 4);
      chk({t2h, t2l, f2, irq}, 18'h00003);
      clrp(6'h30);
      go(3'h4, 20);
      {eex, cc} = 2'h3;
      ttc_pins_i.pulses(4'h8, 1);
      chk({c_hi, c_lo, t2h, t2l, ef, irq}, 34'h000140003);
      // Up reload on wrap and on an external edge.
      {cp, eex, cc} = 3'h0;
      clrp(6'h30);
      wr(SEL_CAPLO, 8'h34);
      wr(SEL_CAPHI, 8'h12);
      t2w(16'hFFFF);
      go(3'h4, 4);
      chk({t2h, t2l, f2}, 17'h02469);
      t2w(16'h0000);
      eex = 1'b1;
      ttc_pins_i.pulses(4'h8, 1);
      chk({t2h, t2l, ef}, 17'h02469);
      // Up/down: down match loads all ones, up wrap reloads.
      {eex, dc} = 2'h1;
      clrp(6'h30);
      ttc_pins_i.level(4'h8, 2'h2);
      t2w(16'h1234);
      go(3'h4, 4);
      chk({t2h, t2l, f2, ef}, 18'h3FFFF);
      clrp(6'h10);
      chk({ef, irq}, 2'h2);
      ttc_pins_i.level(4'h8, 2'h3);
      t2w(16'hFFFF);
      go(3'h4, 4);
      chk({t2h, t2l, f2, ef}, 18'h048D2);
      // Baud mode via each select, then pin-two counting.
      dc = 1'b0;
      for (i = 1; i < 3; i++) begin
         bd = 2'(i);
         clrp(6'h30);
         t2w(16'hFFFF);
         go(3'h4, 4);
         chk({t2h, t2l, f2}, 17'h02468);
      end
      {src, eex, r2} = 3'h7;
      ttc_pins_i.pulses(4'hC, 2);
      r2 = 1'b0;
      chk({t2h, t2l, ef, irq}, 18'h048DB);
      close_out();
   end
endmodule : testbench
